// file: rtl/xbwm_pkg.sv
package xbwm_pkg;
  // Bus geometry
  localparam int XBWM_ADDR_W = 16;
  localparam int XBWM_DATA_W = 16;
  localparam int XBWM_WS_W = 3;
  localparam int XBWM_REG_AW = 4;

  // Register offsets, byte addresses
  localparam logic [3:0] XBWM_WSCFG_OFS = 4'h0;
  localparam logic [3:0] XBWM_SYS_CTRL_STATUS_REG2_OFS = 4'h4;
  localparam logic [3:0] XBWM_CTRL_OFS = 4'h8;
  localparam logic [3:0] XBWM_STAT_OFS = 4'hC;

  // Wait-state config fields, one 3-bit count per space
  localparam int XBWM_WS_PROG_LSB = 0;
  localparam int XBWM_WS_DATA_LSB = 3;
  localparam int XBWM_WS_IO_LSB = 6;
  localparam int XBWM_WSCFG_USED = 9;
  // One wait state in every space out of reset
  localparam logic [15:0] XBWM_WSCFG_RST = 16'h0049;

  // Second system control/status register: boot mode bit
  localparam int XBWM_SYS_CTRL_STATUS_REG2_MODE_BIT = 2;

  // Own control and status bits
  localparam int XBWM_CTRL_VIS_BIT = 0;
  localparam logic XBWM_CTRL_VIS_RST = 1'b0;
  localparam int XBWM_STAT_BUSY_BIT = 0;
  localparam int XBWM_STAT_ILL_BIT = 1;

  // Execution start address in either boot space
  localparam logic [15:0] XBWM_BOOT_VECTOR = 16'h0000;

  // External spaces
  typedef enum logic [1:0] {
    XBWM_SP_PROG = 2'b00,
    XBWM_SP_DATA = 2'b01,
    XBWM_SP_IO = 2'b10
  } xbwm_space_t;

  // Access sequencer states
  typedef enum logic [1:0] {
    XBWM_ST_IDLE = 2'b00,
    XBWM_ST_ACCESS = 2'b01,
    XBWM_ST_READY = 2'b10
  } xbwm_state_t;
endpackage

// file: rtl/xbwm_wait_cnt.sv
module xbwm_wait_cnt #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  // Status
  output logic zero
);
  logic [WIDTH-1:0] cnt_q;

  // Refused at elaboration, a zero-width counter cannot count
  if (WIDTH < 1) begin : g_width_check
    $error("xbwm_wait_cnt: WIDTH must be at least 1");
  end

  // Down counter that parks at zero until reloaded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - WIDTH'(1);
    end
  end

  assign zero = (cnt_q == '0);
endmodule

// file: rtl/xbwm_ctrl.sv
// What this block does
// R1: Slow external device pulls ready low, access stretches
// R2: Ready low: wait one cycle, sample again
// R3: Ready sampled only with one or more wait states
// R4: Software should program at least one wait state
// R5: Strap low at reset: boot internal at 0000h
// R6: Strap high at reset: boot external at 0000h
// R7: Strap level held in mode bit 2
// R8: Enable pin high turns on external interface
// R9: Enable low: no external bus, data access illegal
// R10: Visibility enable low while driving bus in visibility
// R11: External decode may use visibility enable against contention
// R12: Sixteen address pins, bit n on pin n
// R13: Space strobes high except during own access
// R14: Access strobe low for every off-chip cycle
// R15: Address, strobes, direction stable through wait states
module xbwm_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Straps
  input wire logic boot_space_select,
  input wire logic ext_if_enable,
  // Core access request
  input wire logic req_valid,
  output logic req_ready,
  input wire xbwm_pkg::xbwm_space_t req_space,
  input wire logic req_write,
  input wire logic [xbwm_pkg::XBWM_ADDR_W-1:0] req_addr,
  output logic done,
  output logic illegal_addr,
  // Boot selection
  output logic boot_external,
  output logic [xbwm_pkg::XBWM_ADDR_W-1:0] boot_addr,
  // External bus
  input wire logic ready,
  output logic [xbwm_pkg::XBWM_ADDR_W-1:0] ext_addr,
  output logic program_space_strobe_n,
  output logic data_space_strobe_n,
  output logic io_space_strobe_n,
  output logic ext_access_strobe_n,
  output logic ext_rd_wr_n,
  output logic visibility_out_enable_n,
  // Register port
  input wire logic [xbwm_pkg::XBWM_REG_AW-1:0] reg_addr,
  input wire logic [xbwm_pkg::XBWM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [xbwm_pkg::XBWM_DATA_W-1:0] reg_rdata
);
  import xbwm_pkg::*;

  xbwm_state_t state_q;
  xbwm_state_t state_d;
  logic [XBWM_WSCFG_USED-1:0] wscfg_q;
  logic vis_mode_q;
  logic boot_mode_q;
  logic ill_sticky_q;
  logic [XBWM_WS_W-1:0] ws_sel;
  logic [XBWM_WS_W-1:0] ws_q;
  logic take;
  logic take_ok;
  logic take_bad;
  logic cnt_zero;
  logic finish;
  logic stat_wr_clr;

  // Requests are only taken when the sequencer is idle
  assign req_ready = (state_q == XBWM_ST_IDLE);
  assign take = req_valid && req_ready;
  // Without the external interface the data space does not exist
  assign take_bad = take && !ext_if_enable && (req_space == XBWM_SP_DATA); // see R9
  assign take_ok = take && ext_if_enable; // see R8

  // Wait-state count for the requested space
  always_comb begin
    case (req_space)
      XBWM_SP_PROG: ws_sel = wscfg_q[XBWM_WS_PROG_LSB +: XBWM_WS_W];
      XBWM_SP_DATA: ws_sel = wscfg_q[XBWM_WS_DATA_LSB +: XBWM_WS_W];
      XBWM_SP_IO: ws_sel = wscfg_q[XBWM_WS_IO_LSB +: XBWM_WS_W];
      default: ws_sel = wscfg_q[XBWM_WS_PROG_LSB +: XBWM_WS_W];
    endcase
  end

  // Software wait states counted here; ready is looked at afterwards
  xbwm_wait_cnt #(
    .WIDTH(XBWM_WS_W)
  ) u_wait_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(take_ok),
    .load_val(ws_sel),
    .zero(cnt_zero)
  );

  // Wait count of the access in flight, kept for the ready decision
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ws_q <= '0;
    end else if (take_ok) begin
      ws_q <= ws_sel;
    end
  end

  // Access sequencer
  always_comb begin
    state_d = state_q;
    finish = 1'b0;
    case (state_q)
      XBWM_ST_IDLE: begin
        if (take_ok) begin
          state_d = XBWM_ST_ACCESS;
        end
      end
      XBWM_ST_ACCESS: begin
        if (cnt_zero) begin
          if (ws_q == '0) begin
            // Zero wait states: ready is never looked at
            finish = 1'b1; // see R3
          end else if (ready) begin
            finish = 1'b1; // see R2
          end else begin
            state_d = XBWM_ST_READY; // see R1
          end
        end
      end
      XBWM_ST_READY: begin
        // One cycle per look at ready until it is seen high
        if (ready) begin
          finish = 1'b1; // see R2
        end
      end
      default: begin
        state_d = XBWM_ST_IDLE;
      end
    endcase
    if (finish) begin
      state_d = XBWM_ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= XBWM_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Address and direction latched once; frozen until the access ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_addr <= '0;
      ext_rd_wr_n <= 1'b1;
    end else if (take_ok) begin
      ext_addr <= req_addr; // see R12
      ext_rd_wr_n <= !req_write; // see R15
    end else if (finish) begin
      ext_rd_wr_n <= 1'b1;
    end
  end

  // Strobes: one space strobe plus the common strobe per off-chip cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      program_space_strobe_n <= 1'b1;
      data_space_strobe_n <= 1'b1;
      io_space_strobe_n <= 1'b1;
      ext_access_strobe_n <= 1'b1;
    end else if (take_ok) begin
      program_space_strobe_n <= (req_space != XBWM_SP_PROG); // see R13
      data_space_strobe_n <= (req_space != XBWM_SP_DATA); // see R13
      io_space_strobe_n <= (req_space != XBWM_SP_IO); // see R13
      ext_access_strobe_n <= 1'b0; // see R14
    end else if (finish) begin
      program_space_strobe_n <= 1'b1;
      data_space_strobe_n <= 1'b1;
      io_space_strobe_n <= 1'b1;
      ext_access_strobe_n <= 1'b1; // see R14
    end
  end

  // Visibility enable low only while a write drives the data bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      visibility_out_enable_n <= 1'b1;
    end else if (take_ok && req_write && vis_mode_q) begin
      visibility_out_enable_n <= 1'b0; // see R10
    end else if (finish) begin
      visibility_out_enable_n <= 1'b1; // see R10
    end
  end

  // Completion and illegal-address pulses; a refused request ends at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done <= 1'b0;
      illegal_addr <= 1'b0;
    end else begin
      done <= finish || (take && !ext_if_enable);
      illegal_addr <= take_bad; // see R9
    end
  end

  // Strap captured on every reset cycle, so its last level counts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_mode_q <= boot_space_select; // see R7
    end
  end

  // Boot space follows the captured mode; vector fixed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_external <= 1'b0;
      boot_addr <= XBWM_BOOT_VECTOR;
    end else begin
      boot_external <= boot_mode_q; // see R5
      boot_addr <= XBWM_BOOT_VECTOR; // see R6
    end
  end

  // Wait-state config and visibility mode written by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wscfg_q <= XBWM_WSCFG_RST[XBWM_WSCFG_USED-1:0]; // see R4
      vis_mode_q <= XBWM_CTRL_VIS_RST;
    end else if (reg_wr) begin
      if (reg_addr == XBWM_WSCFG_OFS) begin
        wscfg_q <= reg_wdata[XBWM_WSCFG_USED-1:0];
      end
      if (reg_addr == XBWM_CTRL_OFS) begin
        vis_mode_q <= reg_wdata[XBWM_CTRL_VIS_BIT];
      end
    end
  end

  // Sticky illegal flag; write one clears, a new event wins
  assign stat_wr_clr = reg_wr && (reg_addr == XBWM_STAT_OFS) && reg_wdata[XBWM_STAT_ILL_BIT];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ill_sticky_q <= 1'b0;
    end else if (take_bad) begin
      ill_sticky_q <= 1'b1; // see R9
    end else if (stat_wr_clr) begin
      ill_sticky_q <= 1'b0;
    end
  end

  // Read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          XBWM_WSCFG_OFS: reg_rdata[XBWM_WSCFG_USED-1:0] <= wscfg_q;
          XBWM_SYS_CTRL_STATUS_REG2_OFS: reg_rdata[XBWM_SYS_CTRL_STATUS_REG2_MODE_BIT] <= boot_mode_q; // see R7
          XBWM_CTRL_OFS: reg_rdata[XBWM_CTRL_VIS_BIT] <= vis_mode_q;
          XBWM_STAT_OFS: begin
            reg_rdata[XBWM_STAT_BUSY_BIT] <= (state_q != XBWM_ST_IDLE);
            reg_rdata[XBWM_STAT_ILL_BIT] <= ill_sticky_q;
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_idle_strobes_high;
    (state_q == XBWM_ST_IDLE) |-> (program_space_strobe_n && data_space_strobe_n
      && io_space_strobe_n && ext_access_strobe_n);
  endproperty
  a_idle_strobes_high: assert property (p_idle_strobes_high) else $error("strobe low while idle"); // see R13

  property p_one_space_with_access;
    !ext_access_strobe_n |-> ($countones({program_space_strobe_n, data_space_strobe_n,
      io_space_strobe_n}) == 2);
  endproperty
  a_one_space_with_access: assert property (p_one_space_with_access) else $error("strobe mismatch"); // see R14

  property p_zero_ws_ignores_ready;
    (state_q == XBWM_ST_ACCESS && ws_q == '0) |=> (done && ext_access_strobe_n);
  endproperty
  a_zero_ws_ignores_ready: assert property (p_zero_ws_ignores_ready) else $error("zero ws stalled"); // see R3

  property p_ready_low_stretches;
    (state_q != XBWM_ST_IDLE && cnt_zero && ws_q != '0 && !ready)
      |=> (!ext_access_strobe_n && !done);
  endproperty
  a_ready_low_stretches: assert property (p_ready_low_stretches) else $error("ready ignored"); // see R1

  property p_ready_high_ends;
    (state_q != XBWM_ST_IDLE && cnt_zero && ws_q != '0 && ready)
      |=> (done && ext_access_strobe_n);
  endproperty
  a_ready_high_ends: assert property (p_ready_high_ends) else $error("ready high not ended"); // see R2

  property p_hold_stable;
    (!ext_access_strobe_n ##1 !ext_access_strobe_n) |-> ($stable(ext_addr)
      && $stable(ext_rd_wr_n) && $stable(data_space_strobe_n));
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("bus moved in wait"); // see R15

  property p_illegal_data;
    (take && !ext_if_enable && req_space == XBWM_SP_DATA)
      |=> (illegal_addr && data_space_strobe_n) ##1 ill_sticky_q;
  endproperty
  a_illegal_data: assert property (p_illegal_data) else $error("no illegal flag"); // see R9

  property p_disabled_no_cycle;
    (take && !ext_if_enable) |=> (ext_access_strobe_n && done);
  endproperty
  a_disabled_no_cycle: assert property (p_disabled_no_cycle) else $error("cycle while off"); // see R8

  property p_visibility_out_enable;
    !visibility_out_enable_n |-> (vis_mode_q && !ext_rd_wr_n && !ext_access_strobe_n);
  endproperty
  a_visibility_out_enable: assert property (p_visibility_out_enable) else $error("visibility enable wrong"); // see R10

  property p_mode_read;
    (reg_rd && reg_addr == XBWM_SYS_CTRL_STATUS_REG2_OFS)
      |=> (reg_rdata[XBWM_SYS_CTRL_STATUS_REG2_MODE_BIT] == boot_external);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode bit wrong"); // see R7

  c_zero_ws: cover property (take_ok && ws_sel == '0);
  c_ready_stall: cover property (state_q == XBWM_ST_READY ##1 done);
  c_illegal: cover property (illegal_addr);
  c_vis_write: cover property (!visibility_out_enable_n);
endmodule

// file: tb/xbwm_ext_dev.sv
module xbwm_ext_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus from the controller
  input wire logic ext_access_strobe_n,
  input wire logic ext_rd_wr_n,
  input wire logic visibility_out_enable_n,
  // Slowness chosen by the bench
  input wire logic [7:0] low_cycles,
  // Answers
  output logic ready,
  output logic data_drive_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] age_q;

  // Cycles since the access strobe fell
  always_ff @(posedge clk) begin
    if (sys_rst || ext_access_strobe_n) age_q <= 8'h00;
    else age_q <= age_q + 8'h01;
  end

  // Not ready for the first cycles of an access; the pull-up holds it high when idle
  assign ready = !(!ext_access_strobe_n && age_q < low_cycles);

  // Read data driven only while the controller keeps off the bus
  assign data_drive_en = !ext_access_strobe_n && ext_rd_wr_n && visibility_out_enable_n;
endmodule

// file: tb/xbwm_ctrl_tb.sv
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module xbwm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import xbwm_pkg::*;
  logic clk, sys_rst, boot_space_select, ext_if_enable, req_valid, req_ready, req_write;
  logic done, illegal_addr, boot_external, ready, ps_n, ds_n, is_n, as_n, rd_wr_n, vis_n;
  logic reg_wr, reg_rd, data_drive_en, wr, vis;
  xbwm_space_t req_space;
  logic [15:0] req_addr, boot_addr, ext_addr, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  logic [7:0] low_cycles;
  logic [31:0] lfsr_q;
  logic [2:0] n;
  logic [1:0] slow;
  int fail_count, tests_run, cyc;

  xbwm_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .boot_space_select(boot_space_select),
    .ext_if_enable(ext_if_enable), .req_valid(req_valid), .req_ready(req_ready),
    .req_space(req_space), .req_write(req_write), .req_addr(req_addr), .done(done),
    .illegal_addr(illegal_addr), .boot_external(boot_external), .boot_addr(boot_addr),
    .ready(ready), .ext_addr(ext_addr), .program_space_strobe_n(ps_n),
    .data_space_strobe_n(ds_n), .io_space_strobe_n(is_n), .ext_access_strobe_n(as_n),
    .ext_rd_wr_n(rd_wr_n), .visibility_out_enable_n(vis_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  xbwm_ext_dev i_dev (.clk(clk), .sys_rst(sys_rst), .ext_access_strobe_n(as_n),
    .ext_rd_wr_n(rd_wr_n), .visibility_out_enable_n(vis_n), .low_cycles(low_cycles),
    .ready(ready), .data_drive_en(data_drive_en));

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Zero waits ignore ready; otherwise each low sample adds a cycle
  function automatic int exp_cycles(input int wn, input int sl);
    return (wn == 0) ? 2 : wn + 2 + sl;
  endfunction

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk);
    boot_space_select <= strap;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("boot_external", strap, boot_external)
    `CHK("boot_addr", XBWM_BOOT_VECTOR, boot_addr)
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  // One request; every cycle up to done is checked at the pins
  task automatic do_access(input xbwm_space_t sp, input logic w, input logic [15:0] a,
                           input int n_cyc, input logic v);
    logic bus;
    logic [2:0] sb;
    bus = (n_cyc > 1);
    @(posedge clk);
    req_valid <= 1'b1;
    req_space <= sp;
    req_write <= w;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    // First look is in the cycle right after the take edge
    for (int i = 1; i <= n_cyc; i++) begin
      if (i > 1) @(posedge clk);
      #1;
      sb = (bus && i < n_cyc) ? ~(3'b001 << sp) : 3'b111;
      `CHK("space_strobes", sb, {is_n, ds_n, ps_n})
      `CHK("access_strobe", !(bus && i < n_cyc), as_n)
      `CHK("done", i == n_cyc, done)
      `CHK("req_ready", !(bus && i < n_cyc), req_ready)
      `CHK("illegal", !bus && sp == XBWM_SP_DATA && i == 1, illegal_addr)
      if (bus && i < n_cyc) begin
        `CHK("ext_addr", a, ext_addr)
        `CHK("rd_wr_n", !w, rd_wr_n)
        `CHK("visibility_out_enable_n", !(v && w), vis_n)
        `CHK("dev_drive", !w, data_drive_en)
      end
    end
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    boot_space_select = 1'b0;
    ext_if_enable = 1'b1;
    req_valid = 1'b0;
    req_space = XBWM_SP_PROG;
    req_write = 1'b0;
    req_addr = 16'h0000;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    low_cycles = 8'h00;
    lfsr_q = 32'hDE167C78;
    // Both strap levels, second one as a mid-run reset
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      reg_check(XBWM_SYS_CTRL_STATUS_REG2_OFS, 16'(s) << XBWM_SYS_CTRL_STATUS_REG2_MODE_BIT, "mode_bit");
    end
    reg_check(XBWM_WSCFG_OFS, XBWM_WSCFG_RST, "wscfg_reset");
    reg_check(XBWM_CTRL_OFS, 16'h0000, "ctrl_reset");
    reg_check(4'h2, 16'h0000, "unmapped");
    // Random waits and slowness, spaces in turn; first three force zero waits with ready low
    for (int k = 0; k < 30; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      n = (k < 3) ? 3'h0 : lfsr_q[2:0];
      slow = (k < 3) ? 2'h3 : lfsr_q[4:3];
      wr = lfsr_q[5];
      vis = lfsr_q[6];
      reg_write(XBWM_WSCFG_OFS, {7'h00, n, n, n});
      reg_write(XBWM_CTRL_OFS, {15'h0000, vis});
      low_cycles <= 8'(n) + 8'(slow);
      do_access(xbwm_space_t'(k % 3), wr, lfsr_q[31:16], exp_cycles(n, slow), vis);
    end
    // External interface off: no bus cycle, data space flagged
    @(posedge clk);
    ext_if_enable <= 1'b0;
    for (int k = 0; k < 3; k++) do_access(xbwm_space_t'(k), 1'b0, 16'h1234, 1, 1'b0);
    reg_check(XBWM_STAT_OFS, 16'h0002, "illegal_sticky");
    // Write one clears the sticky flag
    reg_write(XBWM_STAT_OFS, 16'h0002);
    reg_check(XBWM_STAT_OFS, 16'h0000, "illegal_clear");
    print_verdict();
  end
endmodule
